// [rtl/amss_pkg.sv]
// Constants and types shared by the asynchronous memory strobe sequencer.
// Behaviour
// - Read strobe low for bank wait states.
// - Select and address one clock before read.
// - Hold select, address after read strobe.
// - Same-bank reads: read hold, plus one if idle.
// - Different-bank reads: read hold plus idle cycles.
// - Read then write: hold plus max(idle, 4).
// - Predisable reads: hold+3 or hold+max(idle,3).
// - Address, data stable for write hold.
// - Write gaps: 1+hold to write, 3+hold to read.
// - Drive write data one clock before strobe.
// - Release data bus two clocks before read.
// - Select and address one clock before write.
// - Low acknowledge stretches access until high again.
// - One select per bank, idle when no access.
package amss_pkg;

    // ************************************************************
    // Widths and counts
    // ************************************************************
    localparam int ADDR_W    = 24;
    localparam int DATA_W    = 16;
    localparam int NUM_BANKS = 2;
    localparam int BANK_W    = 1;
    localparam int WS_W      = 5;
    localparam int CYC_W     = 3;
    localparam int GAP_W     = 6;
    localparam int REG_AW    = 5;
    localparam int REG_DW    = 32;

    // ************************************************************
    // Register map and reset values
    // ************************************************************
    localparam logic [REG_AW-1:0] REG_BTC_BASE = 5'h00;
    localparam int                REG_STRIDE   = 4;
    localparam logic [REG_AW-1:0] REG_STATUS   = 5'h10;
    localparam logic [WS_W-1:0]   WS_RESET     = 5'h1f;
    localparam logic [WS_W-1:0]   WS_MIN       = 5'h01;

    // ************************************************************
    // Gap figures in memory clocks
    // ************************************************************
    localparam logic [GAP_W-1:0] GAP_RD_WR   = 6'h04;
    localparam logic [GAP_W-1:0] GAP_PREDISABLE  = 6'h03;
    localparam logic [GAP_W-1:0] GAP_SAME_IC = 6'h01;
    localparam logic [GAP_W-1:0] GAP_WR_WR   = 6'h01;
    localparam logic [GAP_W-1:0] GAP_WR_RD   = 6'h03;
    localparam logic [GAP_W-1:0] CNT_ONE     = 6'h01;
    localparam int               DATA_OFF_LEAD = 2;

    typedef struct packed {
        logic              predisable;
        logic [CYC_W-1:0]  write_hold;
        logic [CYC_W-1:0]  idle_cycles;
        logic [CYC_W-1:0]  read_hold_cycles;
        logic [WS_W-1:0]   wait_states;
    } amss_btc_type;

    localparam amss_btc_type BTC_RESET = '{1'b0, 3'h0, 3'h0, 3'h0, WS_RESET};

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } amss_req_type;

    typedef struct packed {
        logic              busy;
        logic              ack;
        logic              last_write;
        logic [BANK_W-1:0] last_bank;
    } amss_status_type;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_SETUP  = 4'h2,
        ST_STROBE = 4'h4,
        ST_HOLD   = 4'h8
    } amss_state_type;

    function automatic logic [REG_AW-1:0] amss_btc_addr(input int b);
        return REG_BTC_BASE + REG_AW'(b * REG_STRIDE);
    endfunction : amss_btc_addr

endpackage : amss_pkg

// [rtl/amss_sync2.sv]
// Two-flop synchroniser for pin inputs of the strobe sequencer.
`timescale 1ns/1ps
`default_nettype none
module amss_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second; nothing else reads it.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            meta <= '1;
            o_q  <= '1;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule : amss_sync2
`default_nettype wire

// [rtl/amss_sequencer.sv]
// Strobe sequencer that runs asynchronous external memory accesses.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module amss_sequencer (
    input  wire logic                           I_CLK,
    input  wire logic                           I_RST_B,
    input  wire logic                           I_REQ_VALID,
    input  wire amss_pkg::amss_req_type         I_REQ,
    output logic                                O_REQ_READY,
    output logic                                O_RD_VALID,
    output logic [amss_pkg::DATA_W-1:0]         O_RD_DATA,
    output logic [amss_pkg::NUM_BANKS-1:0]      O_BANK_SEL_N,
    output logic [amss_pkg::ADDR_W-1:0]         O_ADDR,
    output logic [amss_pkg::DATA_W-1:0]         O_DATA_OUT,
    output logic                                O_DATA_OE,
    input  wire logic [amss_pkg::DATA_W-1:0]    I_DATA_IN,
    output logic                                O_READ_STROBE_N,
    output logic                                O_WRITE_STROBE_N,
    input  wire logic                           I_ACCESS_ACK,
    input  wire logic [amss_pkg::REG_AW-1:0]    I_REG_ADDR,
    input  wire logic [amss_pkg::REG_DW-1:0]    I_REG_WDATA,
    input  wire logic                           I_REG_WR,
    input  wire logic                           I_REG_RD,
    output logic [amss_pkg::REG_DW-1:0]         O_REG_RDATA
);
    import amss_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    amss_state_type          state;
    amss_state_type          next_state;
    amss_btc_type            btc [NUM_BANKS];
    amss_btc_type            cur_t;
    amss_req_type            cur;
    amss_status_type         status;
    logic                    cur_valid;
    logic [BANK_W-1:0]       cur_bank;
    logic [BANK_W-1:0]       new_bank;
    logic [BANK_W-1:0]       acc_bank;
    logic                    acc_write;
    logic                    accept;
    logic [WS_W-1:0]         ws_eff;
    logic [CYC_W-1:0]        hold_cyc;
    logic [GAP_W-1:0]        cnt;
    logic [GAP_W-1:0]        hi_cnt;
    logic [GAP_W-1:0]        hi_req;
    logic [GAP_W-1:0]        next_hi_req;
    logic                    strobe_done;
    logic                    hold_last;
    logic                    ack_s;
    logic [DATA_W-1:0]       din_s;
    logic [1:0]              cap_pend;
    logic [NUM_BANKS-1:0]    next_sel_n;
    logic [REG_DW-1:0]       next_rdata;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Acknowledge and read data both come from the pins, so each passes two
    // flops; the partner must pull acknowledge low early enough to cover it.
    amss_sync2 #(
        .WIDTH (DATA_W + 1)
    ) u_pin_sync (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_d     ({I_ACCESS_ACK, I_DATA_IN}),
        .o_q     ({ack_s, din_s})
    );

    // ************************************************************
    // Request decode
    // ************************************************************
    // Bank follows the top address bits; timing of the current bank is used.
    assign new_bank    = I_REQ.addr[ADDR_W-1 -: BANK_W];
    assign cur_bank    = cur.addr[ADDR_W-1 -: BANK_W];
    assign cur_t       = btc[cur_bank];
    assign O_REQ_READY = (state == ST_IDLE);
    assign accept      = I_REQ_VALID && O_REQ_READY;
    assign acc_bank    = accept ? new_bank : cur_bank;
    assign acc_write   = accept ? I_REQ.write : cur.write;
    assign ws_eff      = (cur_t.wait_states == '0) ? WS_MIN : cur_t.wait_states;
    assign hold_cyc    = cur.write ? cur_t.write_hold : cur_t.read_hold_cycles;

    // Strobe ends once the wait states ran out and acknowledge is high.
    assign strobe_done = (cnt >= GAP_W'(ws_eff) - CNT_ONE) && ack_s;
    assign hold_last   = (cnt >= GAP_W'(hold_cyc) - CNT_ONE);

    // ************************************************************
    // Strobe high time demanded by the previous access
    // ************************************************************
    // The figures come from the bank that was accessed last.
    always_comb begin
        logic [GAP_W-1:0] rh;
        logic [GAP_W-1:0] ic;
        logic [GAP_W-1:0] wh;
        logic             same;
        rh          = GAP_W'(cur_t.read_hold_cycles);
        ic          = GAP_W'(cur_t.idle_cycles);
        wh          = GAP_W'(cur_t.write_hold);
        same        = (new_bank == cur_bank);
        next_hi_req = '0;
        if (!cur_valid) begin
            next_hi_req = '0;
        end else if (cur.write) begin
            next_hi_req = wh + (I_REQ.write ? GAP_WR_WR : GAP_WR_RD);
        end else if (I_REQ.write) begin
            next_hi_req = rh + ((ic > GAP_RD_WR) ? ic : GAP_RD_WR);
        end else if (!cur_t.predisable) begin
            if (same) begin
                next_hi_req = (ic == '0) ? rh : rh + GAP_SAME_IC;
            end else begin
                next_hi_req = rh + ic;
            end
        end else if (same) begin
            next_hi_req = rh + GAP_PREDISABLE;
        end else begin
            next_hi_req = rh + ((ic > GAP_PREDISABLE) ? ic : GAP_PREDISABLE);
        end
    end

    // ************************************************************
    // Access state machine
    // ************************************************************
    // Setup lasts at least one clock, so select, address and write data
    // always lead the strobe by a clock.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (hi_cnt >= hi_req) begin
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (strobe_done) begin
                    next_state = (hold_cyc == '0) ? ST_IDLE : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (hold_last) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Captured request and the gap that its strobe must respect.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            cur       <= '0;
            cur_valid <= 1'b0;
            hi_req    <= '0;
        end else if (accept) begin
            cur       <= I_REQ;
            cur_valid <= 1'b1;
            hi_req    <= next_hi_req;
        end
    end

    // ************************************************************
    // Counters
    // ************************************************************
    // One counter serves the strobe and hold phases; it restarts at each
    // phase change so a stretched strobe cannot eat into the hold.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            cnt <= '0;
        end else if (state != next_state || state == ST_IDLE || state == ST_SETUP) begin
            cnt <= '0;
        end else if (cnt != '1) begin
            cnt <= cnt + CNT_ONE;
        end
    end

    // Counts strobe high cycles including the present one, saturating.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            hi_cnt <= '0;
        end else if (state == ST_STROBE) begin
            hi_cnt <= CNT_ONE;
        end else if (hi_cnt != '1) begin
            hi_cnt <= hi_cnt + CNT_ONE;
        end
    end

    // ************************************************************
    // Pin outputs
    // ************************************************************
    // One select per bank, all inactive while idle.
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_sel
        assign next_sel_n[b] = !(next_state != ST_IDLE && acc_bank == BANK_W'(b));
    end

    // Strobes and selects are flops so the pins never glitch.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_BANK_SEL_N     <= '1;
            O_READ_STROBE_N  <= 1'b1;
            O_WRITE_STROBE_N <= 1'b1;
        end else begin
            O_BANK_SEL_N     <= next_sel_n;
            O_READ_STROBE_N  <= !(next_state == ST_STROBE && !acc_write);
            O_WRITE_STROBE_N <= !(next_state == ST_STROBE && acc_write);
        end
    end

    // Address and write data load on accept and stay through the hold.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_ADDR     <= '0;
            O_DATA_OUT <= '0;
        end else if (accept) begin
            O_ADDR     <= I_REQ.addr;
            O_DATA_OUT <= I_REQ.wdata;
        end
    end

    // The bus is driven from setup to the end of hold of a write only.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_DATA_OE <= 1'b0;
        end else begin
            O_DATA_OE <= (next_state != ST_IDLE) && acc_write;
        end
    end

    // ************************************************************
    // Read data capture
    // ************************************************************
    // The pin is sampled on the edge the strobe rises; it then needs two
    // more edges through the synchroniser before it can be kept.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            cap_pend   <= '0;
            O_RD_VALID <= 1'b0;
            O_RD_DATA  <= '0;
        end else begin
            cap_pend   <= {cap_pend[0], state == ST_STROBE && strobe_done && !cur.write};
            O_RD_VALID <= cap_pend[1];
            if (cap_pend[1]) begin
                O_RD_DATA <= din_s;
            end
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    // Timing takes effect on the next access; changing it mid-access is
    // allowed but the current phase sees the new figures at once.
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_btc
        always_ff @(posedge I_CLK) begin
            if (!I_RST_B) begin
                btc[b] <= BTC_RESET;
            end else if (I_REG_WR && I_REG_ADDR == amss_btc_addr(b)) begin
                btc[b] <= I_REG_WDATA[$bits(amss_btc_type)-1:0];
            end
        end
    end

    assign status = '{(state != ST_IDLE), ack_s, cur.write, cur_bank};

    // Unmapped reads return zero.
    always_comb begin
        next_rdata = '0;
        if (I_REG_RD) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                if (I_REG_ADDR == amss_btc_addr(b)) begin
                    next_rdata = REG_DW'(btc[b]);
                end
            end
            if (I_REG_ADDR == REG_STATUS) begin
                next_rdata = REG_DW'(status);
            end
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_REG_RDATA <= '0;
        end else begin
            O_REG_RDATA <= next_rdata;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [GAP_W-1:0] low_cnt;
    logic [GAP_W-1:0] gap_cnt;

    // Pin-side counters of strobe low and high cycles.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            low_cnt <= '0;
            gap_cnt <= '0;
        end else begin
            low_cnt <= (O_READ_STROBE_N && O_WRITE_STROBE_N) ? '0 :
                       (low_cnt == '1) ? low_cnt : low_cnt + CNT_ONE;
            gap_cnt <= !(O_READ_STROBE_N && O_WRITE_STROBE_N) ? '0 :
                       (gap_cnt == '1) ? gap_cnt : gap_cnt + CNT_ONE;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    property p_rd_width;
        $rose(O_READ_STROBE_N) |-> low_cnt >= GAP_W'(ws_eff);
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe too short");

    property p_rd_setup;
        $fell(O_READ_STROBE_N) |-> !$past(&O_BANK_SEL_N) && $stable(O_ADDR);
    endproperty
    a_rd_setup: assert property (p_rd_setup) else $error("select late for read");

    property p_rd_hold;
        $rose(&O_BANK_SEL_N) && !cur.write |-> gap_cnt == GAP_W'(cur_t.read_hold_cycles);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read hold wrong");

    property p_gap;
        $fell(O_READ_STROBE_N && O_WRITE_STROBE_N) |-> gap_cnt >= hi_req;
    endproperty
    a_gap: assert property (p_gap) else $error("strobe high time too short");

    property p_wr_width;
        $rose(O_WRITE_STROBE_N) |-> low_cnt >= GAP_W'(ws_eff);
    endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe too short");

    property p_wr_hold;
        $fell(O_DATA_OE) |-> gap_cnt == GAP_W'(cur_t.write_hold) && $stable(O_DATA_OUT);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write hold wrong");

    property p_data_lead;
        $fell(O_WRITE_STROBE_N) |-> $past(O_DATA_OE);
    endproperty
    a_data_lead: assert property (p_data_lead) else $error("write data late");

    property p_data_off;
        $fell(O_READ_STROBE_N) |-> !$past(O_DATA_OE) && !$past(O_DATA_OE, DATA_OFF_LEAD);
    endproperty
    a_data_off: assert property (p_data_off) else $error("bus driven before read");

    property p_wr_setup;
        $fell(O_WRITE_STROBE_N) |-> !$past(&O_BANK_SEL_N);
    endproperty
    a_wr_setup: assert property (p_wr_setup) else $error("select late for write");

    property p_ack_stretch;
        state == ST_STROBE && !ack_s |=> state == ST_STROBE;
    endproperty
    a_ack_stretch: assert property (p_ack_stretch) else $error("ack low ignored");

    property p_idle_sel;
        state == ST_IDLE |-> &O_BANK_SEL_N;
    endproperty
    a_idle_sel: assert property (p_idle_sel) else $error("select active while idle");

    property p_idle_strobe;
        state == ST_IDLE |-> O_READ_STROBE_N && O_WRITE_STROBE_N;
    endproperty
    a_idle_strobe: assert property (p_idle_strobe) else $error("strobe low while idle");

endmodule : amss_sequencer
`default_nettype wire

// [dv/amss_mem_model.sv]
// Behavioural asynchronous memory on the far side of the strobe sequencer.
`timescale 1ns/1ps
`default_nettype none
module amss_mem_model (
    input  wire logic        i_clk,
    input  wire logic [1:0]  i_sel_n,
    input  wire logic [23:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic [3:0]  i_stretch,
    output logic      [15:0] o_data,
    output logic             o_ack
);
    logic [15:0] mem [32];
    logic [3:0]  cnt = 4'h0;
    logic [4:0]  idx;
    assign idx = {i_addr[23], i_addr[3:0]};
    // The bus has pull-ups, so a released bus reads all ones, never the last word.
    assign o_data = (!i_rd_n && i_sel_n != 2'b11) ? mem[idx] : 16'hffff;
    initial o_ack = 1'b1;
    // Acknowledge drops one clock after the select falls, so the sequencer's two
    // synchroniser flops still see it inside the wait states; it then stays low
    // for one clock more than the asked number of strobe-low clocks.
    always @(posedge i_clk) begin
        if (i_sel_n != 2'b11 && cnt < i_stretch) begin
            o_ack <= 1'b0;
            if (!(i_rd_n && i_wr_n)) cnt <= cnt + 4'h1;
        end else begin
            o_ack <= 1'b1;
            if (i_sel_n == 2'b11) cnt <= 4'h0;
        end
        if (!i_wr_n && i_sel_n != 2'b11) mem[idx] <= i_wdata;
    end
endmodule : amss_mem_model
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the asynchronous memory strobe sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import amss_pkg::*;
    typedef struct packed {
        logic w;
        logic b;
        logic [3:0] a;
        logic [15:0] d;
        logic [14:0] cfg;
        logic [3:0] st;
    } amss_acc_type;
    logic         clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    amss_req_type req = '0;
    logic         req_ready, rd_valid, oe, rd_n, wr_n, ack, idle, prev_idle = 1'b1, in_hold = 1'b0;
    logic [15:0]  rd_data, dout, din, mdata, shadow [32];
    logic [1:0]   sel_n;
    logic [23:0]  addr;
    logic [4:0]   reg_addr = '0;
    logic [31:0]  reg_wdata = '0, reg_rdata, v;
    logic [3:0]   stretch = 4'h0;
    logic [14:0]  cfg [2];
    amss_acc_type q[$], prv, cur;
    logic [15:0]  rq[$];
    logic [5:0]   seq [15] = '{6'h21, 6'h32, 6'h23, 6'h01, 6'h03, 6'h12, 6'h12, 6'h01,
                               6'h35, 6'h15, 6'h01, 6'h03, 6'h12, 6'h15, 6'h01};
    int           num_errors = 0, cmp_count = 0, have_prv = 0;
    int           lo, hi, sl, oec, oeoff, gap, lead, oel, offl, wid, i;
    always #25 clk = ~clk;
    assign din = oe ? dout : mdata;
    amss_sequencer amss_sequencer_i (.I_CLK(clk), .I_RST_B(rst_b), .I_REQ_VALID(req_valid),
        .I_REQ(req), .O_REQ_READY(req_ready), .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data),
        .O_BANK_SEL_N(sel_n), .O_ADDR(addr), .O_DATA_OUT(dout), .O_DATA_OE(oe),
        .I_DATA_IN(din), .O_READ_STROBE_N(rd_n), .O_WRITE_STROBE_N(wr_n),
        .I_ACCESS_ACK(ack), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
        .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata));
    amss_mem_model amss_mem_model_i (.i_clk(clk), .i_sel_n(sel_n), .i_addr(addr),
        .i_wdata(dout), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_stretch(stretch),
        .o_data(mdata), .o_ack(ack));
    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic chk_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_eq
    // Lower bound only: the sequencer may add slack to any gap.
    task automatic chk_ge(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if ((g >= e) !== 1'b1) begin
            num_errors++;
            $display("[ERR] %s expected at least %0d seen %0d", nm, e, g);
        end
    endtask : chk_ge
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    // Minimum strobe high time, taken from the previous access's bank settings.
    function automatic int hi_min(amss_acc_type p, amss_acc_type c);
        int rh = p.cfg[7:5], idl = p.cfg[10:8], wh = p.cfg[13:11];
        if (p.w) return c.w ? 1 + wh : 3 + wh;
        if (c.w) return rh + (idl > 4 ? idl : 4);
        if (p.cfg[14]) return (p.b == c.b) ? rh + 3 : rh + (idl > 3 ? idl : 3);
        return (p.b == c.b) ? rh + int'(idl != 0) : rh + idl;
    endfunction : hi_min
    // Pin monitor: measures widths, setup, hold and gaps, then checks each access.
    always @(posedge clk) begin
        idle = rd_n & wr_n;
        if (rd_valid && rq.size() > 0) chk_eq("rd_data", rq.pop_front(), rd_data);
        if (!idle && prev_idle && q.size() > 0) begin
            gap = hi; lead = sl; oel = oec; offl = oeoff; lo = 0;
            chk_eq("sel", q[0].b ? 2'b01 : 2'b10, sel_n);
        end
        if (!idle) lo++;
        if (idle && !prev_idle) begin
            wid = lo; in_hold = 1'b1; sl = 0; oec = 0;
        end
        hi = idle ? hi + 1 : 0;
        if (sel_n == 2'b11) begin
            if (in_hold && q.size() > 0) begin
                cur = q.pop_front();
                chk_ge("setup", 1, lead);
                if (cur.st != 0) chk_ge("stretch", cur.st + 1, wid);
                else chk_eq("width", cur.cfg[4:0], wid);
                chk_eq("hold", cur.w ? cur.cfg[13:11] : cur.cfg[7:5], sl);
                chk_eq("addr", {cur.b, 19'h0, cur.a}, addr);
                if (cur.w) chk_ge("oe_lead", 1, oel);
                if (cur.w) chk_eq("oe_hold", cur.cfg[13:11], oec);
                if (cur.w) chk_eq("wdata", cur.d, dout);
                else chk_ge("oe_off", 2, offl);
                if (have_prv != 0) chk_ge("gap", hi_min(prv, cur), gap);
                prv = cur; have_prv = 1; oec = 0;
            end
            in_hold = 1'b0; sl = 0;
        end else if (idle) sl++;
        oec = oe ? (idle ? oec + 1 : oec) : 0;
        oeoff = oe ? 0 : oeoff + 1;
        prev_idle = idle;
    end
    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : reg_read
    task automatic set_bank(input logic b, input int ws, rh, idl, wh, pd);
        cfg[b] = {1'(pd), 3'(wh), 3'(idl), 3'(rh), 5'(ws)};
        reg_write(b ? 5'h04 : 5'h00, {17'h0, cfg[b]});
    endtask : set_bank
    // Requests are held until taken; the next one may follow at once.
    task automatic access(input logic [5:0] s);
        amss_acc_type t;
        int n = 0;
        @(posedge clk);
        t = '{s[5], s[4], s[3:0], 16'hc3a0 + 16'(cmp_count), cfg[s[4]], stretch};
        req_valid <= 1'b1;
        req <= '{t.w, {t.b, 19'h0, t.a}, t.d};
        do begin @(posedge clk); n++; end while (!req_ready && n < 300);
        req_valid <= 1'b0;
        q.push_back(t);
        if (t.w) shadow[{t.b, t.a}] = t.d;
        else rq.push_back(shadow[{t.b, t.a}]);
        if (n >= 300) begin num_errors++; conclude(); end
    endtask : access
    task automatic drain();
        for (int n = 0; n < 400 && (q.size() + rq.size()) != 0; n++) @(posedge clk);
        if (q.size() + rq.size() != 0) begin num_errors++; conclude(); end
        repeat (4) @(posedge clk);
    endtask : drain
    // Main sequence: register checks, then mixed, predisabled and stretched traffic.
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        reg_read(5'h00, v); chk_eq("bank0_reset", 32'h1f, v);
        reg_read(5'h14, v); chk_eq("unmapped", 0, v);
        reg_write(5'h04, 32'hffff_ffff);
        reg_read(5'h04, v); chk_eq("bank1_mask", 32'h7fff, v);
        set_bank(0, 3, 2, 0, 1, 0); set_bank(1, 4, 1, 5, 3, 0);
        for (i = 0; i < 10; i++) access(seq[i]);
        drain();
        set_bank(0, 3, 2, 0, 1, 1); set_bank(1, 4, 1, 5, 3, 1);
        for (i = 10; i < 15; i++) access(seq[i]);
        drain();
        stretch <= 4'h7;
        access(6'h15); access(6'h24);
        drain();
        stretch <= 4'h0;
        chk_eq("sel_idle", 2'b11, sel_n);
        chk_eq("strobes_idle", 2'b11, {rd_n, wr_n});
        conclude();
    end
    // A hang anywhere ends in the closing report.
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule : tb
`default_nettype wire
